// *** verilog/fieldbus_slave_data_map.sv ***
// fieldbus slave data map: config check, input image, parameter changes, diagnosis
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_data_map #(
  parameter logic [15:0] UNIT_ID = fieldbus_map_pkg::UNIT_ID_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [fieldbus_map_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fieldbus_map_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger_pin,
  input wire logic data_exchange,
  input wire logic cfg_start,
  input wire logic cfg_valid,
  input wire logic [7:0] cfg_byte,
  input wire logic cfg_end,
  output logic cfg_ok,
  output logic cfg_error,
  output logic [5:0] in_len,
  input wire logic [5:0] in_rd_addr,
  output logic [7:0] in_rd_data,
  input wire logic out_wr_valid,
  input wire logic [4:0] out_wr_addr,
  input wire logic [7:0] out_wr_data,
  input wire logic out_frame_end,
  output logic param_apply,
  output logic [2:0] change_selector_byte,
  input wire logic [31:0] std_diag,
  input wire logic [4:0] diag_rd_addr,
  output logic [7:0] diag_rd_data
);
  import fieldbus_map_pkg::*;

  // start-up blocks of heads two to eight are handled by the link engine; last block base
  localparam int PRM_LAST_BASE = PRM_HEAD2_BASE + (HEADS - 2) * PRM_HEAD_STRIDE;

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic trig_s1;
    logic trig_s2;
    logic [15:0] box_temp;
    logic [HEADS-1:0] connected;
    logic [4:0] box_err;
    logic [CMD_BYTES-1:0][7:0] err_cmd;
    logic [HEADS-1:0][15:0] obj_temp;
    logic [HEADS-1:0][15:0] head_temp;
    logic [HEADS-1:0][4:0] head_err;
    logic [HEADS-1:0][15:0] param_val;
    logic [OUT_BYTES-1:0][7:0] out_buf;
    cfg_state_t cfg_st;
    logic [3:0] cfg_cnt;
    logic cfg_bad;
    logic cfg_ok;
    logic cfg_error;
    logic [3:0] head_count;
    logic [7:0] in_data;
    logic [7:0] diag_data;
    logic apply;
    logic [2:0] last_type;
    logic [7:0] apply_cnt;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // head n is registered when the configuration names it
  function automatic logic registered(input logic [3:0] count, input int n);
    return (4'(n) < count);
  endfunction

  function automatic logic [5:0] input_length(input logic [3:0] count);
    return IN_HEAD_BASE + 6'(IN_HEAD_BYTES) * {2'b00, count};
  endfunction

  logic [3:0] highest;
  always_comb begin
    highest = 4'h0;
    for (int n = 0; n < HEADS; n++) begin
      if (st_r.connected[n]) begin
        highest = 4'(n + 1);
      end
    end
  end

  logic [7:0] in_byte;
  logic [5:0] in_off;
  logic [2:0] in_head;
  always_comb begin
    in_off = in_rd_addr - IN_HEAD_BASE;
    in_head = in_off[4:2];
    in_byte = 8'h00;
    if (in_rd_addr >= input_length(st_r.head_count)) begin
      in_byte = 8'h00;
    end else if (in_rd_addr == IN_TRIG) begin
      in_byte = {7'h00, st_r.trig_s2};
    end else if (in_rd_addr == IN_BOX_HI) begin
      in_byte = st_r.box_temp[15:8];
    end else if (in_rd_addr == IN_BOX_LO) begin
      in_byte = st_r.box_temp[7:0];
    end else begin
      // unconnected but configured heads still fill their slots
      case (in_off[1:0])
        2'd0: in_byte = st_r.obj_temp[in_head][15:8];
        2'd1: in_byte = st_r.obj_temp[in_head][7:0];
        2'd2: in_byte = st_r.head_temp[in_head][15:8];
        default: in_byte = st_r.head_temp[in_head][7:0];
      endcase
    end
  end

  logic [7:0] dg_byte;
  logic [4:0] dg_idx;
  always_comb begin
    dg_byte = 8'h00;
    dg_idx = 5'h00;
    if (diag_rd_addr < DG_ID_HI) begin
      dg_byte = std_diag[8*(3 - int'(diag_rd_addr[1:0])) +: 8];
    end else if (diag_rd_addr == DG_ID_HI) begin
      dg_byte = UNIT_ID[15:8];
    end else if (diag_rd_addr == DG_ID_LO) begin
      dg_byte = UNIT_ID[7:0];
    end else if (diag_rd_addr == DG_SIZE) begin
      dg_byte = DIAG_EXT_SIZE;
    end else if (diag_rd_addr == DG_HIGHEST) begin
      dg_byte = {4'h0, highest};
    end else if (diag_rd_addr == DG_BOX_ERR) begin
      dg_byte = {3'h0, st_r.box_err};
    end else if (diag_rd_addr >= DG_CMD_FIRST && diag_rd_addr <= DG_CMD_LAST) begin
      dg_idx = diag_rd_addr - DG_CMD_FIRST;
      dg_byte = st_r.err_cmd[dg_idx];
    end else if (diag_rd_addr >= DG_HEAD_FIRST && diag_rd_addr <= DG_HEAD_LAST) begin
      dg_idx = diag_rd_addr - DG_HEAD_FIRST;
      if (registered(st_r.head_count, int'(dg_idx))) begin
        dg_byte = {1'b0, ~st_r.connected[dg_idx[2:0]], 1'b0, st_r.head_err[dg_idx[2:0]]};
      end
    end
  end

  logic [31:0] rd_word;
  logic rd_hit;
  logic [2:0] ar_head;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    ar_head = s_axi_araddr[4:2];
    if (s_axi_araddr[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end else if (s_axi_araddr == REG_STATUS) begin
      rd_word = {10'h000, in_len, 4'h0, st_r.head_count, highest,
                 1'b0, st_r.trig_s2, st_r.cfg_error, st_r.cfg_ok};
    end else if (s_axi_araddr == REG_BOX_TEMP) begin
      rd_word = {16'h0000, st_r.box_temp};
    end else if (s_axi_araddr == REG_CONNECTED) begin
      rd_word = {24'h000000, st_r.connected};
    end else if (s_axi_araddr == REG_BOX_ERR) begin
      rd_word = {27'h0000000, st_r.box_err};
    end else if (s_axi_araddr == REG_CMD0) begin
      rd_word = st_r.err_cmd[3:0];
    end else if (s_axi_araddr == REG_CMD1) begin
      rd_word = st_r.err_cmd[7:4];
    end else if (s_axi_araddr == REG_CMD2) begin
      rd_word = {8'h00, st_r.err_cmd[10:8]};
    end else if (s_axi_araddr == REG_PARAM_STAT) begin
      rd_word = {16'h0000, st_r.apply_cnt, 5'h00, st_r.last_type};
    end else if (s_axi_araddr[7:5] == REG_HEAD_TEMP[7:5]) begin
      rd_word = {st_r.head_temp[ar_head], st_r.obj_temp[ar_head]};
    end else if (s_axi_araddr[7:5] == REG_HEAD_ERR[7:5]) begin
      rd_word = {27'h0000000, st_r.head_err[ar_head]};
    end else if (s_axi_araddr[7:5] == REG_PARAM_VAL[7:5]) begin
      rd_word = {16'h0000, st_r.param_val[ar_head]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    logic [31:0] cur;
    logic [2:0] wh;
    logic [2:0] ptype;
    logic wr_hit;
    cur = 32'h0000_0000;
    wh = st_r.aw_addr[4:2];
    ptype = st_r.out_buf[OUT_TYPE][2:0];
    wr_hit = 1'b1;
    st_nxt = st_r;
    st_nxt.apply = 1'b0;
    st_nxt.trig_s1 = trigger_pin;
    st_nxt.trig_s2 = st_r.trig_s1;
    st_nxt.in_data = in_byte;
    st_nxt.diag_data = dg_byte;

    // register write: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.aw_held && st_r.w_held) begin
      if (st_r.aw_addr[1:0] != 2'b00) begin
        wr_hit = 1'b0;
      end else if (st_r.aw_addr == REG_BOX_TEMP) begin
        cur = wmerge({16'h0000, st_r.box_temp}, st_r.w_data, st_r.w_strb);
        st_nxt.box_temp = cur[15:0];
      end else if (st_r.aw_addr == REG_CONNECTED) begin
        cur = wmerge({24'h000000, st_r.connected}, st_r.w_data, st_r.w_strb);
        st_nxt.connected = cur[7:0];
      end else if (st_r.aw_addr == REG_BOX_ERR) begin
        cur = wmerge({27'h0000000, st_r.box_err}, st_r.w_data, st_r.w_strb);
        st_nxt.box_err = cur[4:0];
      end else if (st_r.aw_addr == REG_CMD0) begin
        st_nxt.err_cmd[3:0] = wmerge(st_r.err_cmd[3:0], st_r.w_data, st_r.w_strb);
      end else if (st_r.aw_addr == REG_CMD1) begin
        st_nxt.err_cmd[7:4] = wmerge(st_r.err_cmd[7:4], st_r.w_data, st_r.w_strb);
      end else if (st_r.aw_addr == REG_CMD2) begin
        cur = wmerge({8'h00, st_r.err_cmd[10:8]}, st_r.w_data, st_r.w_strb);
        st_nxt.err_cmd[10:8] = cur[23:0];
      end else if (st_r.aw_addr[7:5] == REG_HEAD_TEMP[7:5]) begin
        cur = wmerge({st_r.head_temp[wh], st_r.obj_temp[wh]}, st_r.w_data, st_r.w_strb);
        st_nxt.obj_temp[wh] = cur[15:0];
        st_nxt.head_temp[wh] = cur[31:16];
      end else if (st_r.aw_addr[7:5] == REG_HEAD_ERR[7:5]) begin
        cur = wmerge({27'h0000000, st_r.head_err[wh]}, st_r.w_data, st_r.w_strb);
        st_nxt.head_err[wh] = cur[4:0];
      end else begin
        wr_hit = 1'b0;
      end
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // register read
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // configuration check: box module first, then one to eight heads
    case (st_r.cfg_st)
      CFG_IDLE: begin
        if (cfg_start) begin
          st_nxt.cfg_st = CFG_COLLECT;
          st_nxt.cfg_cnt = 4'h0;
          st_nxt.cfg_bad = 1'b0;
        end
      end
      CFG_COLLECT: begin
        if (cfg_valid) begin
          if (st_r.cfg_cnt == 4'h0) begin
            st_nxt.cfg_bad = st_r.cfg_bad | (cfg_byte != CFG_CODE_BOX);
          end else begin
            st_nxt.cfg_bad = st_r.cfg_bad | (cfg_byte != CFG_CODE_HEAD) | (st_r.cfg_cnt > 4'(HEADS));
          end
          if (st_r.cfg_cnt != 4'hf) begin
            st_nxt.cfg_cnt = st_r.cfg_cnt + 4'h1;
          end
        end
        if (cfg_end) begin
          st_nxt.cfg_st = CFG_IDLE;
          if (!st_r.cfg_bad && st_r.cfg_cnt >= 4'h2) begin
            st_nxt.cfg_ok = 1'b1;
            st_nxt.cfg_error = 1'b0;
            st_nxt.head_count = st_r.cfg_cnt - 4'h1;
          end else begin
            st_nxt.cfg_ok = 1'b0;
            st_nxt.cfg_error = 1'b1;
            st_nxt.head_count = 4'h0;
          end
        end
      end
      default: st_nxt.cfg_st = CFG_IDLE;
    endcase

    // cyclic output bytes are staged, then applied at frame end
    if (out_wr_valid && data_exchange && 32'(out_wr_addr) < OUT_BYTES) begin
      st_nxt.out_buf[out_wr_addr] = out_wr_data;
    end
    if (out_frame_end && data_exchange && st_r.cfg_ok) begin
      if (st_r.out_buf[OUT_TYPE] != 8'h00 && st_r.out_buf[OUT_TYPE][7:3] == 5'h00) begin
        for (int n = 0; n < HEADS; n++) begin
          // slot values pass unscaled to the head settings
          st_nxt.param_val[n] = {st_r.out_buf[2*n + 1], st_r.out_buf[2*n + 2]};
        end
        st_nxt.apply = 1'b1;
        st_nxt.last_type = ptype;
        st_nxt.apply_cnt = st_r.apply_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.cfg_st <= CFG_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign cfg_ok = st_r.cfg_ok;
  assign cfg_error = st_r.cfg_error;
  assign in_len = input_length(st_r.head_count);
  assign in_rd_data = st_r.in_data;
  assign diag_rd_data = st_r.diag_data;
  assign param_apply = st_r.apply;
  assign change_selector_byte = st_r.last_type;
endmodule
`default_nettype wire

// *** verilog/fieldbus_map_pkg.sv ***
// constants shared by the fieldbus slave data map
package fieldbus_map_pkg;
  localparam int HEADS = 8;
  localparam int ADDR_W = 8;
  // configuration identifiers of box module and head
  localparam logic [7:0] CFG_CODE_BOX = 8'h12;
  localparam logic [7:0] CFG_CODE_HEAD = 8'h51;
  // start-up parameter telegram: head 2 block and stride
  localparam int PRM_HEAD2_BASE = 64;
  localparam int PRM_HEAD_STRIDE = 20;
  localparam int PRM_HEAD8_BASE = 184;
  localparam int PRM_RSVD_FIRST = 60;
  localparam int PRM_RSVD_LAST = 63;
  // cyclic input layout
  localparam logic [5:0] IN_TRIG = 6'h00;
  localparam logic [5:0] IN_BOX_HI = 6'h01;
  localparam logic [5:0] IN_BOX_LO = 6'h02;
  localparam logic [5:0] IN_HEAD_BASE = 6'h03;
  localparam int IN_HEAD_BYTES = 4;
  // cyclic output layout
  localparam logic [4:0] OUT_TYPE = 5'h00;
  localparam int OUT_BYTES = 17;
  localparam logic [2:0] TYPE_NONE = 3'h0;
  localparam logic [2:0] TYPE_EMISSIVITY = 3'h1;
  localparam logic [2:0] TYPE_LASER = 3'h2;
  localparam logic [2:0] TYPE_BACKGROUND = 3'h3;
  localparam logic [2:0] TYPE_AVERAGING = 3'h4;
  localparam logic [2:0] TYPE_PEAK_HOLD = 3'h5;
  localparam logic [2:0] TYPE_VALLEY_HOLD = 3'h6;
  localparam logic [2:0] TYPE_RELAY_SET = 3'h7;
  // diagnosis layout
  localparam logic [4:0] DG_ID_HI = 5'h04;
  localparam logic [4:0] DG_ID_LO = 5'h05;
  localparam logic [4:0] DG_SIZE = 5'h06;
  localparam logic [4:0] DG_HIGHEST = 5'h0a;
  localparam logic [4:0] DG_BOX_ERR = 5'h0b;
  localparam logic [4:0] DG_CMD_FIRST = 5'h0c;
  localparam logic [4:0] DG_CMD_LAST = 5'h16;
  localparam logic [4:0] DG_HEAD_FIRST = 5'h17;
  localparam logic [4:0] DG_HEAD_LAST = 5'h1e;
  localparam logic [7:0] DIAG_EXT_SIZE = 8'h19;
  localparam int CMD_BYTES = 11;
  localparam int HEAD_ERR_NOCONN_BIT = 6;
  // register map, byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_BOX_TEMP = 8'h04;
  localparam logic [7:0] REG_CONNECTED = 8'h08;
  localparam logic [7:0] REG_BOX_ERR = 8'h0c;
  localparam logic [7:0] REG_CMD0 = 8'h10;
  localparam logic [7:0] REG_CMD1 = 8'h14;
  localparam logic [7:0] REG_CMD2 = 8'h18;
  localparam logic [7:0] REG_PARAM_STAT = 8'h20;
  localparam logic [7:0] REG_HEAD_TEMP = 8'h40;
  localparam logic [7:0] REG_HEAD_ERR = 8'h60;
  localparam logic [7:0] REG_PARAM_VAL = 8'h80;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // arbitrary neutral identifier value
  localparam logic [15:0] UNIT_ID_DEFAULT = 16'h1234;
  typedef enum logic [0:0] {CFG_IDLE, CFG_COLLECT} cfg_state_t;
endpackage

// *** testbench/fieldbus_slave_data_map_assertions.sv ***
// concurrent checks on the fieldbus slave data map ports
`timescale 1ns/1ps
`default_nettype none
module fieldbus_map_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cfg_end,
  input wire logic cfg_ok,
  input wire logic cfg_error,
  input wire logic [5:0] in_len,
  input wire logic [5:0] in_rd_addr,
  input wire logic [7:0] in_rd_data,
  input wire logic data_exchange,
  input wire logic out_frame_end,
  input wire logic param_apply,
  input wire logic [2:0] change_selector_byte,
  input wire logic [4:0] diag_rd_addr,
  input wire logic [7:0] diag_rd_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence cfg_result;
    cfg_ok ^ cfg_error;
  endsequence
  cfg_excl_a: assert property (!(cfg_ok && cfg_error)) else $error("config ok and error together");
  cfg_result_a: assert property (cfg_end |=> cfg_result) else $error("no config result");
  len_bad_a: assert property (!cfg_ok |-> in_len == 6'd3) else $error("input length not 3");
  len_ok_a: assert property (
    cfg_ok |-> in_len >= 6'd7 && in_len <= 6'd35 && in_len[1:0] == 2'b11) else $error("input length off");
  in_pad_a: assert property (
    in_rd_addr >= in_len |=> in_rd_data == 8'h00) else $error("byte past length not zero");
  trig_byte_a: assert property (
    in_rd_addr == 6'h00 |=> in_rd_data[7:1] == 7'h00) else $error("trigger byte upper bits set");
  apply_cause_a: assert property (
    param_apply |-> $past(out_frame_end) && $past(data_exchange) && $past(cfg_ok)) else $error("apply without frame");
  apply_type_a: assert property (
    param_apply |=> change_selector_byte != 3'h0) else $error("apply with type zero");
  apply_pulse_a: assert property (param_apply |=> !param_apply) else $error("apply too long");
  diag_size_a: assert property (
    diag_rd_addr == 5'h06 |=> diag_rd_data == 8'h19) else $error("diagnosis size wrong");
  diag_rsvd_a: assert property (
    diag_rd_addr inside {5'h07, 5'h08, 5'h09, 5'h1f} |=> diag_rd_data == 8'h00) else $error("reserved nonzero");
endmodule
`default_nettype wire

// *** testbench/fieldbus_master_model.sv ***
// bus master model: configuration check and cyclic output frames
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model
  import fieldbus_map_pkg::*;
(
  input wire logic aclk,
  output logic data_exchange,
  output logic cfg_start,
  output logic cfg_valid,
  output logic [7:0] cfg_byte,
  output logic cfg_end,
  output logic out_wr_valid,
  output logic [4:0] out_wr_addr,
  output logic [7:0] out_wr_data,
  output logic out_frame_end
);
  initial begin
    {data_exchange, cfg_start, cfg_valid, cfg_byte, cfg_end} = '0;
    {out_wr_valid, out_wr_addr, out_frame_end} = '0;
    out_wr_data = 8'h00;
  end
  // box module first then n heads; bad puts a head code first
  task automatic configure(input int n, input logic bad);
    cfg_start <= 1'b1;
    @(posedge aclk);
    cfg_start <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      cfg_valid <= 1'b1;
      cfg_byte <= (i == 0 && !bad) ? CFG_CODE_BOX : CFG_CODE_HEAD;
      @(posedge aclk);
    end
    cfg_valid <= 1'b0;
    cfg_byte <= ~cfg_byte;
    cfg_end <= 1'b1;
    @(posedge aclk);
    cfg_end <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // slot n (from 0) carries {tag, n + 1}, high byte first; gap idles between bytes
  task automatic frame(input logic [7:0] t, input logic [7:0] tag, input logic dx, input int gap);
    data_exchange <= dx;
    for (int i = 0; i < OUT_BYTES; i++) begin
      out_wr_valid <= 1'b1;
      out_wr_addr <= 5'(i);
      out_wr_data <= (i == 0) ? t : (i % 2 == 1 ? tag : 8'(i / 2));
      @(posedge aclk);
      if (gap > 0) begin
        out_wr_valid <= 1'b0;
        out_wr_data <= ~out_wr_data;
        repeat (gap) @(posedge aclk);
      end
    end
    out_wr_valid <= 1'b0;
    out_wr_data <= ~out_wr_data;
    out_frame_end <= 1'b1;
    @(posedge aclk);
    out_frame_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/fieldbus_slave_data_map_bench.sv ***
// self-checking bench for the fieldbus slave data map
`timescale 1ns/1ps
`default_nettype none
module fieldbus_slave_data_map_bench;
  import fieldbus_map_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic trigger_pin = 1'b1;
  logic [5:0] in_len, in_rd_addr = '0;
  logic [4:0] diag_rd_addr = '0, out_wr_addr;
  logic [7:0] in_rd_data, diag_rd_data, cfg_byte, out_wr_data, t, tag, last_tag;
  logic [31:0] std_diag = 32'h080c0001;
  logic data_exchange, cfg_start, cfg_valid, cfg_end, cfg_ok, cfg_error, out_wr_valid, out_frame_end;
  logic param_apply, seen, ap;
  logic [2:0] change_selector_byte, last_t;
  logic [7:0] mask = 8'h05;
  int num_errors = 0, checks = 0, cnt = 0;
  fieldbus_slave_data_map dut_u (.*);
  fieldbus_master_model master_u (.*);
  initial forever #4 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
      if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  function automatic logic [7:0] in_exp(int a, int len);
    if (a >= len) return 8'h00;
    if (a < 3) return a == 2 ? 8'h23 : 8'h01;
    return 8'(8'h10 + 8'h20 * ((a - 3) % 4) + (a - 3) / 4);
  endfunction
  function automatic logic [7:0] dg_exp(int a, int nh);
    int h;
    h = a - 23;
    if (a < 4) return std_diag[31 - 8 * a -: 8];
    if (a == 4) return UNIT_ID_DEFAULT[15:8];
    if (a == 5) return UNIT_ID_DEFAULT[7:0];
    if (a == 6) return DIAG_EXT_SIZE;
    if (a == 10) return 8'h03;
    if (a == 11) return 8'h15;
    if (a >= 12 && a <= 22) return 8'(8'h41 + a - 12);
    if (h >= 0 && h < nh && a < 31) return {1'b0, !mask[h], 1'b0, 5'(h + 1)};
    return 8'h00;
  endfunction
  task automatic in_scan(input int len);
    for (int a = 0; a <= len; a++) begin
      in_rd_addr <= 6'(a);
      repeat (2) @(posedge aclk);
      chk("input byte", {24'h0, in_rd_data}, {24'h0, in_exp(a, len)});
    end
  endtask
  task automatic dg_scan(input int lo, input int nh);
    for (int a = lo; a < 32; a++) begin
      diag_rd_addr <= 5'(a);
      repeat (2) @(posedge aclk);
      chk("diag byte", {24'h0, diag_rd_data}, {24'h0, dg_exp(a, nh)});
    end
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("reset ok", {cfg_ok, cfg_error}, 0);
    chk("reset len", in_len, 3);
    axi_wr(REG_BOX_TEMP, 32'h0123);
    axi_wr(REG_CONNECTED, {24'h0, mask});
    axi_wr(REG_BOX_ERR, 32'h15);
    axi_wr(REG_CMD0, 32'h44434241);
    axi_wr(REG_CMD1, 32'h48474645);
    axi_wr(REG_CMD2, 32'h004b4a49);
    for (int h = 0; h < HEADS; h++) begin
      axi_wr(REG_HEAD_TEMP + 8'(4 * h), 32'h50701030 + 32'h01010101 * h);
      axi_wr(REG_HEAD_ERR + 8'(4 * h), 32'(h + 1));
    end
    axi_wr(8'hfc, 32'h1);
    chk("unmapped write", resp, RESP_SLVERR);
    axi_rd(8'hfc);
    chk("unmapped read", resp, RESP_SLVERR);
    master_u.configure(1, 1'b0);
    chk("one head len", {cfg_ok, in_len}, {1'b1, 6'd7});
    in_scan(7);
    dg_scan(23, 1);
    master_u.configure(8, 1'b1);
    chk("bad config", {cfg_error, in_len}, {1'b1, 6'd3});
    master_u.configure(8, 1'b0);
    chk("eight heads len", {cfg_ok, in_len}, {1'b1, 6'd35});
    in_scan(35);
    trigger_pin <= 1'b0;
    in_rd_addr <= IN_TRIG;
    repeat (4) @(posedge aclk);
    chk("trigger low", {24'h0, in_rd_data}, 32'h0);
    axi_rd(REG_STATUS);
    chk("status word", d, 32'h0023_0831);
    dg_scan(0, 8);
    last_t = 0;
    last_tag = 0;
    for (int s = 0; s < 10; s++) begin
      t = s < 7 ? 8'(s + 1) : (s == 7 ? 8'h00 : (s == 8 ? 8'h03 : 8'h0b));
      tag = 8'(8'h80 + s);
      ap = t != 0 && t < 8 && s != 8;
      master_u.frame(t, tag, s != 8, s % 3);
      seen = 0;
      repeat (3) begin
        @(posedge aclk);
        seen |= param_apply;
      end
      if (ap) begin
        last_t = t[2:0];
        last_tag = tag;
        cnt++;
      end
      chk("apply", seen, ap);
      chk("selector", change_selector_byte, last_t);
      for (int h = 0; h < HEADS; h++) begin
        axi_rd(REG_PARAM_VAL + 8'(4 * h));
        chk("param value", d[15:0], {last_tag, 8'(h + 1)});
      end
    end
    axi_rd(REG_PARAM_STAT);
    chk("apply count", d[15:8], cnt);
    test_done();
  end
endmodule
bind fieldbus_slave_data_map fieldbus_map_checker chk_u (.*);
`default_nettype wire
